// [hdl/pfc_ctrl_bytes.sv]
// programmed cpu frequency control bytes with strap capture and ratio selection
//
// Behaviour
// R1 - enabled: frequency from factor a and b
// R2 - factor b write starts frequency load
// R3 - bypass clear: ratio from latched straps
// R4 - bypass set: ratio from software select
// R5 - enable byte bit 7 enables, resets zero
// R6 - status bits 7:3 show straps, read-only
// R7 - factors reset zero, hold last write
// R8 - disabled: frequency from straps or select
// R9 - host writes ones to test, zeros reserved
`timescale 1ns/1ps
`default_nettype none

module pfc_ctrl_bytes #(
	parameter int SETTLE_CYC = pfc_pkg::STRAP_SETTLE_CYC
) (
	// clock and reset
	input  wire logic                         clock_i,
	input  wire logic                         rst_i,
	// control byte port from the smbus engine
	input  wire logic                         byte_wr_i,
	input  wire logic                         byte_rd_i,
	input  wire logic [7:0]                   byte_addr_i,
	input  wire logic [7:0]                   byte_wdata_i,
	output logic      [7:0]                   byte_rdata_o,
	output logic                              byte_rvalid_o,
	// frequency-select strap pins
	input  wire logic [pfc_pkg::STRAP_W-1:0]  strap_pins_i,
	// fields held in other control bytes
	input  wire logic                         strap_bypass_i,
	input  wire logic [pfc_pkg::STRAP_W-1:0]  soft_freq_select_i,
	// frequency control towards the pll
	output pfc_pkg::pfc_freq_cfg_t            freq_cfg_o,
	output logic                              freq_load_o,
	output logic                              use_programmed_o,
	output logic                              strap_valid_o
);

	// ----------------------------------------------------------------
	// parameter check
	// ----------------------------------------------------------------
	// the strap settle counter is only eight bits wide
	if (SETTLE_CYC < 1 || SETTLE_CYC > 255)
	begin : g_bad_settle
		$error("pfc_ctrl_bytes: unsupported settle count");
	end

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [pfc_pkg::FACT_A_W-1:0] factor_a_q;
	logic [pfc_pkg::FACT_B_W-1:0] factor_b_q;
	logic                         prog_en_q;
	logic [1:0]                   test_bits_q;
	logic [pfc_pkg::STRAP_W-1:0]  strap_val;
	logic [pfc_pkg::STRAP_W-1:0]  ratio_sel_q;
	logic                         load_q;
	logic                         wr_a;
	logic                         wr_b;
	logic                         wr_st;

	assign wr_a  = byte_wr_i && (byte_addr_i == pfc_pkg::OFS_FACTOR_A);
	assign wr_b  = byte_wr_i && (byte_addr_i == pfc_pkg::OFS_EN_FACT_B);
	assign wr_st = byte_wr_i && (byte_addr_i == pfc_pkg::OFS_STRAP_ST);

	// straps are caught after reset release, not at the pins each cycle
	pfc_strap_latch #(
		.WIDTH      (pfc_pkg::STRAP_W),
		.SETTLE_CYC (SETTLE_CYC)
	) u_strap (
		.clock_i      (clock_i),
		.rst_i        (rst_i),
		.strap_pins_i (strap_pins_i),
		.strap_val_o  (strap_val),
		.strap_done_o (strap_valid_o)
	);

	// ----------------------------------------------------------------
	// writable bytes
	// ----------------------------------------------------------------
	// first factor byte
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			factor_a_q <= pfc_pkg::RST_FACTOR_A; // R7
		else if (wr_a)
			factor_a_q <= byte_wdata_i; // R7
	end

	// enable bit and second factor share one byte
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			prog_en_q  <= pfc_pkg::RST_PROG_EN; // R5
			factor_b_q <= pfc_pkg::RST_FACTOR_B; // R7
		end
		else if (wr_b)
		begin
			prog_en_q  <= byte_wdata_i[pfc_pkg::BIT_PROG_EN]; // R5
			factor_b_q <= byte_wdata_i[pfc_pkg::FACT_B_W-1:0]; // R7
		end
	end

	// only the two test bits of the status byte store; strap bits ignore writes
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			test_bits_q <= pfc_pkg::RST_TEST_BITS;
		else if (wr_st)
			test_bits_q <= byte_wdata_i[1:0]; // R9
	end

	// ----------------------------------------------------------------
	// frequency control
	// ----------------------------------------------------------------
	// every write to the second factor byte reloads, even with same value
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			load_q <= 1'b0;
		else
			load_q <= wr_b; // R2
	end

	// ratio source; also the whole frequency source while disabled
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			ratio_sel_q <= '0;
		else if (strap_bypass_i)
			ratio_sel_q <= soft_freq_select_i; // R4 R8
		else
			ratio_sel_q <= strap_val; // R3 R8
	end

	assign freq_load_o          = load_q;
	assign use_programmed_o     = prog_en_q; // R1 R8
	// one driver for the whole carrier, so no member is driven twice
	assign freq_cfg_o = '{
		prog_en:   prog_en_q,
		factor_a:  factor_a_q, // R1
		factor_b:  factor_b_q, // R1
		ratio_sel: ratio_sel_q
	};

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// reserved bytes and unmapped offsets read zero
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			byte_rdata_o  <= pfc_pkg::READ_UNMAPPED;
			byte_rvalid_o <= 1'b0;
		end
		else
		begin
			byte_rvalid_o <= byte_rd_i;
			if (byte_rd_i)
			begin
				case (byte_addr_i)
					pfc_pkg::OFS_FACTOR_A:  byte_rdata_o <= factor_a_q;
					pfc_pkg::OFS_EN_FACT_B: byte_rdata_o <= {prog_en_q, factor_b_q};
					pfc_pkg::OFS_STRAP_ST:  byte_rdata_o <= {strap_val, 1'b0, test_bits_q}; // R6
					default:                byte_rdata_o <= pfc_pkg::READ_UNMAPPED;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	chk_load_on_write: assert property (@(posedge clock_i) disable iff (rst_i) // R2
		wr_b |=> freq_load_o ##1 !freq_load_o || $past(wr_b))
		else $error("no single load pulse after factor b write");

	chk_load_no_cause: assert property (@(posedge clock_i) disable iff (rst_i) // R2
		freq_load_o |-> $past(wr_b))
		else $error("load pulse without factor b write");

	chk_ratio_straps: assert property (@(posedge clock_i) disable iff (rst_i) // R3
		!strap_bypass_i |=> freq_cfg_o.ratio_sel == $past(strap_val))
		else $error("ratio not from straps");

	chk_ratio_soft: assert property (@(posedge clock_i) disable iff (rst_i) // R4
		strap_bypass_i |=> freq_cfg_o.ratio_sel == $past(soft_freq_select_i))
		else $error("ratio not from software select");

	chk_enable_write: assert property (@(posedge clock_i) disable iff (rst_i) // R5
		wr_b |=> use_programmed_o == $past(byte_wdata_i[7]))
		else $error("enable bit not taken from bit 7");

	chk_strap_readonly: assert property (@(posedge clock_i) disable iff (rst_i) // R6
		(wr_st && strap_valid_o) |=> $stable(strap_val))
		else $error("strap bits changed by write");

	chk_factor_hold: assert property (@(posedge clock_i) disable iff (rst_i) // R7
		!wr_a && !wr_b |=> $stable(freq_cfg_o.factor_a) && $stable(freq_cfg_o.factor_b))
		else $error("factor changed without write");

	chk_status_read: assert property (@(posedge clock_i) disable iff (rst_i) // R6
		(byte_rd_i && byte_addr_i == pfc_pkg::OFS_STRAP_ST)
		|=> byte_rvalid_o && byte_rdata_o[7:3] == $past(strap_val) && !byte_rdata_o[2])
		else $error("status byte read wrong");

	chk_source_switch: assert property (@(posedge clock_i) disable iff (rst_i) // R1 R8
		$changed(use_programmed_o) |-> $past(wr_b))
		else $error("frequency source changed without enable byte write");

	chk_factor_a_write: assert property (@(posedge clock_i) disable iff (rst_i) // R7
		wr_a |=> freq_cfg_o.factor_a == $past(byte_wdata_i))
		else $error("factor a not taken from write");

	chk_factor_b_write: assert property (@(posedge clock_i) disable iff (rst_i) // R7
		wr_b |=> freq_cfg_o.factor_b == $past(byte_wdata_i[pfc_pkg::FACT_B_W-1:0]))
		else $error("factor b not taken from write");

	chk_load_only_b: assert property (@(posedge clock_i) disable iff (rst_i) // R2
		(wr_a && !wr_b) |=> !freq_load_o)
		else $error("load pulse after factor a write alone");

endmodule : pfc_ctrl_bytes

`default_nettype wire

// [hdl/pfc_pkg.sv]
// shared constants and carrier types for the programmed cpu frequency control bytes
package pfc_pkg;

	// ----------------------------------------------------------------
	// control byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_FACTOR_A  = 8'h0d;
	localparam logic [7:0] OFS_EN_FACT_B = 8'h0e;
	localparam logic [7:0] OFS_STRAP_ST  = 8'h0f;
	localparam logic [7:0] OFS_SPARE_ONE = 8'h10;
	localparam logic [7:0] OFS_SPARE_TWO = 8'h11;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int         BIT_PROG_EN    = 7;
	localparam int         STRAP_LSB      = 3;
	localparam int         STRAP_W        = 5;
	localparam int         FACT_A_W       = 8;
	localparam int         FACT_B_W       = 7;
	localparam logic [7:0] RST_FACTOR_A   = 8'h00;
	localparam logic [6:0] RST_FACTOR_B   = 7'h00;
	localparam logic       RST_PROG_EN    = 1'b0;
	localparam logic [1:0] RST_TEST_BITS  = 2'h3;
	localparam logic [7:0] READ_UNMAPPED  = 8'h00;

	// ----------------------------------------------------------------
	// timing: settle time before straps are captured
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS    = 100;
	localparam int STRAP_SETTLE_NS  = 400;
	localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// programmed-frequency configuration handed to the pll control
	typedef struct packed {
		logic                prog_en;
		logic [FACT_A_W-1:0] factor_a;
		logic [FACT_B_W-1:0] factor_b;
		logic [STRAP_W-1:0]  ratio_sel;
	} pfc_freq_cfg_t;

endpackage : pfc_pkg

// [hdl/pfc_strap_latch.sv]
// synchronises the frequency-select straps and captures them once after reset
`timescale 1ns/1ps
`default_nettype none

module pfc_strap_latch #(
	parameter int WIDTH      = pfc_pkg::STRAP_W,
	parameter int SETTLE_CYC = pfc_pkg::STRAP_SETTLE_CYC
) (
	// clock and reset
	input  wire logic             clock_i,
	input  wire logic             rst_i,
	// strap pins and captured value
	input  wire logic [WIDTH-1:0] strap_pins_i,
	output logic      [WIDTH-1:0] strap_val_o,
	output logic                  strap_done_o
);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// elaboration refuses widths and settle counts the 8-bit counter cannot serve
	if (WIDTH < 1 || SETTLE_CYC < 1 || SETTLE_CYC > 255)
	begin : g_bad_params
		$error("pfc_strap_latch: unsupported parameters");
	end

	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [7:0]       settle_q;

	// three-stage synchroniser; the first stage feeds only the second
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end
		else
		begin
			s1_q <= strap_pins_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// settle counter; capture happens once, after release, never under reset
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			settle_q     <= 8'h00;
			strap_val_o  <= '0;
			strap_done_o <= 1'b0;
		end
		else if (!strap_done_o)
		begin
			if (settle_q < 8'(SETTLE_CYC))
				settle_q <= settle_q + 8'h01;
			else if (s2_q == s3_q)
			begin
				strap_val_o  <= s3_q;
				strap_done_o <= 1'b1;
			end
		end
	end

endmodule : pfc_strap_latch

`default_nettype wire

// [verification/pfc_host_model.sv]
// host-side model issuing single control byte reads and writes
`timescale 1ns/1ps
`default_nettype none

module pfc_host_model (
	// clock
	input  wire logic       clock_i,
	// byte port towards the device
	output logic            byte_wr_o,
	output logic            byte_rd_o,
	output logic [7:0]      byte_addr_o,
	output logic [7:0]      byte_wdata_o,
	input  wire logic [7:0] byte_rdata_i,
	input  wire logic       byte_rvalid_i
);
	// ------------------------------------------------------------
	// idle: unqualified lines carry junk, never a stale value
	// ------------------------------------------------------------
	initial
	begin
		byte_wr_o    = 1'b0;
		byte_rd_o    = 1'b0;
		byte_addr_o  = 8'h5a;
		byte_wdata_o = 8'ha5;
	end

	// one byte write; callers keep test bits at one and spare bits at zero
	task automatic wr_byte(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clock_i);
		#1;
		byte_addr_o  = addr;
		byte_wdata_o = data;
		byte_wr_o    = 1'b1;
		@(posedge clock_i);
		#1;
		byte_wr_o    = 1'b0;
		byte_addr_o  = ~addr;
		byte_wdata_o = ~data;
	endtask : wr_byte

	// one byte read; answer sampled in the cycle after the strobe edge
	task automatic rd_byte(input logic [7:0] addr, output logic [7:0] d, output logic v);
		@(posedge clock_i);
		#1;
		byte_addr_o = addr;
		byte_rd_o   = 1'b1;
		@(posedge clock_i);
		#1;
		byte_rd_o   = 1'b0;
		byte_addr_o = ~addr;
		d           = byte_rdata_i;
		v           = byte_rvalid_i;
	endtask : rd_byte
endmodule : pfc_host_model
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench for the programmed cpu frequency control bytes
`timescale 1ns/1ps
`default_nettype none

module testbench;
	localparam logic [4:0] STRAPS = 5'h16;
	logic                   clk, rst, wr, rd, rvalid, load, use_prog, strap_valid, bypass;
	logic [7:0]             addr, wdata, rdata;
	logic [4:0]             soft_sel;
	pfc_pkg::pfc_freq_cfg_t cfg;
	int                     miscompares, checked, cycles;

	pfc_host_model u_host (.clock_i(clk), .byte_wr_o(wr), .byte_rd_o(rd),
		.byte_addr_o(addr), .byte_wdata_o(wdata), .byte_rdata_i(rdata),
		.byte_rvalid_i(rvalid));

	pfc_ctrl_bytes #(.SETTLE_CYC(4)) u_dut (.clock_i(clk), .rst_i(rst), .byte_wr_i(wr),
		.byte_rd_i(rd), .byte_addr_i(addr), .byte_wdata_i(wdata), .byte_rdata_o(rdata),
		.byte_rvalid_o(rvalid), .strap_pins_i(STRAPS), .strap_bypass_i(bypass),
		.soft_freq_select_i(soft_sel), .freq_cfg_o(cfg), .freq_load_o(load),
		.use_programmed_o(use_prog), .strap_valid_o(strap_valid));

	// ------------------------------------------------------------
	// clock, hang guard and reporting
	// ------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ceiling far above the few dozen cycles the sequence needs
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 600)
		begin
			miscompares++;
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       v;
		u_host.rd_byte(a, d, v);
		chk({what, " valid"}, 8'h01, {7'h0, v});
		chk(what, exp, d);
	endtask : rd_chk

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		rst      = 1'b1;
		bypass   = 1'b0;
		soft_sel = 5'h09;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		for (int i = 0; i < 20 && strap_valid !== 1'b1; i++) @(posedge clk);
		chk("strap valid", 8'h01, {7'h0, strap_valid});
		rd_chk("factor a reset", pfc_pkg::OFS_FACTOR_A, 8'h00);
		rd_chk("enable byte reset", pfc_pkg::OFS_EN_FACT_B, 8'h00);
		rd_chk("strap status", pfc_pkg::OFS_STRAP_ST, {STRAPS, 3'h3});
		rd_chk("spare one", pfc_pkg::OFS_SPARE_ONE, 8'h00);
		rd_chk("spare two", pfc_pkg::OFS_SPARE_TWO, 8'h00);
		rd_chk("unmapped", 8'h20, 8'h00);
		// disabled programming: ratio follows the bypass bit
		chk("ratio straps", {3'h0, STRAPS}, {3'h0, cfg.ratio_sel});
		#1 bypass = 1'b1;
		repeat (2) @(posedge clk);
		chk("ratio soft", 8'h09, {3'h0, cfg.ratio_sel});
		// factor a alone must not start a load
		u_host.wr_byte(pfc_pkg::OFS_FACTOR_A, 8'ha5);
		chk("no load on factor a", 8'h00, {7'h0, load});
		chk("factor a out", 8'ha5, cfg.factor_a);
		u_host.wr_byte(pfc_pkg::OFS_EN_FACT_B, 8'h85);
		chk("load on factor b", 8'h01, {7'h0, load});
		chk("prog enable", 8'h01, {7'h0, cfg.prog_en});
		chk("use programmed", 8'h01, {7'h0, use_prog});
		chk("factor b out", 8'h05, {1'b0, cfg.factor_b});
		@(posedge clk);
		#1;
		chk("load pulse ends", 8'h00, {7'h0, load});
		// two writes of factor b, one idle cycle apart, each load; the first (8'h7f) already disables
		u_host.wr_byte(pfc_pkg::OFS_EN_FACT_B, 8'h7f);
		u_host.wr_byte(pfc_pkg::OFS_EN_FACT_B, 8'h2a);
		chk("second load", 8'h01, {7'h0, load});
		chk("use programmed off", 8'h00, {7'h0, use_prog});
		#1 bypass = 1'b0;
		repeat (2) @(posedge clk);
		chk("ratio back to straps", {3'h0, STRAPS}, {3'h0, cfg.ratio_sel});
		// straps are read-only; spare bytes keep zero
		u_host.wr_byte(pfc_pkg::OFS_STRAP_ST, 8'h03);
		u_host.wr_byte(pfc_pkg::OFS_SPARE_ONE, 8'h00);
		rd_chk("strap status kept", pfc_pkg::OFS_STRAP_ST, {STRAPS, 3'h3});
		rd_chk("enable byte held", pfc_pkg::OFS_EN_FACT_B, 8'h2a);
		rd_chk("factor a held", pfc_pkg::OFS_FACTOR_A, 8'ha5);
		// mid-run reset: bytes return to power-on values, straps are caught again
		u_host.wr_byte(pfc_pkg::OFS_EN_FACT_B, 8'h81);
		chk("enable before reset", 8'h01, {7'h0, use_prog});
		#1 rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		chk("enable after reset", 8'h00, {7'h0, use_prog});
		chk("factor a after reset", 8'h00, cfg.factor_a);
		chk("factor b after reset", 8'h00, {1'b0, cfg.factor_b});
		chk("strap valid cleared", 8'h00, {7'h0, strap_valid});
		for (int i = 0; i < 20 && strap_valid !== 1'b1; i++) @(posedge clk);
		rd_chk("strap status recaught", pfc_pkg::OFS_STRAP_ST, {STRAPS, 3'h3});
		summarize();
	end
endmodule : testbench
`default_nettype wire
